//--- rtl/cycle_divider.sv
// Oscillator-to-instruction-cycle divider.
`timescale 1ns/100ps
`default_nettype none
module cycle_divider
    import power_save_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_run,
    output logic      o_tick
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic             next_tick;

    // =========================================================
    // Divide by ten
    // =========================================================
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (i_run) begin
            if (count == DIV_LAST) begin
                next_count = '0;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 4'h1;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count  <= '0;
            o_tick <= 1'b0;
        end else if (i_ce) begin
            count  <= next_count;
            o_tick <= next_tick;
        end
    end

    property p_div_ten;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && o_tick && i_run) |-> ##1 !o_tick;
    endproperty
    a_div_ten: assert property (p_div_ten)
        else $error("Divider tick repeated.");
endmodule
`default_nettype wire

//--- rtl/halt_idle_power_save_control.sv
// Power-save sequencer: full-stop and idle modes with wakeup and start-up.
//
// Summary of operation
// - Stop-request flag write enters full-stop mode.
// - Full-stop stops clocks, timers, supervisory detector.
// - Enabled clock monitor flags fault during full-stop.
// - Enabled wakeup edge leaves full-stop mode.
// - Rising oscillator output pin leaves full-stop with RC clock option.
// - Reset pin low leaves full-stop mode.
// - Start-up delay loads 256, then enables clocks.
// - Instruction clock is oscillator divided by ten.
// - RC start-up delay follows select bit; reset clears.
// - Stop disabled by option: flag stays zero.
// - State kept in both modes except idle timer.
// - Idle flag stops all but oscillator-side timers.
// - Reset or wakeup edge leaves idle mode.
// - Idle exits on selected interval timer period.
// - Bit twelve transition raises gated timer request.
// - Enabled timer interrupt serviced before resuming.
// - Disabled timer interrupt resumes after idle entry.
// - Interval timer free running, no software access.
// - Reset clears interval select to shortest tap.
// - Select codes map to 4096..65536 cycles.
// - Pending and enable bits five, four; global gate.
// - Refuse full-stop while wakeup enabled and pending.
`timescale 1ns/100ps
`default_nettype none
module halt_idle_power_save_control
    import power_save_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    input  wire logic                i_ce,
    input  wire logic                i_reset_pin_n,
    input  wire logic                i_halt_option_enable,
    input  wire logic                i_rc_clock_option,
    input  wire logic                i_stop_request_port_bit_wr,
    input  wire logic                i_idle_request_port_bit_wr,
    input  wire logic                i_startup_delay_select_wr,
    input  wire logic                i_startup_delay_select_val,
    input  wire logic                i_interval_select_wr,
    input  wire logic [IDLE_INTERVAL_SELECT_REG_W-1:0]   i_interval_select_field,
    input  wire logic                i_idle_timer_irq_enable,
    input  wire logic                i_idle_timer_irq_pending_clr,
    input  wire logic                i_global_irq_enable,
    input  wire logic                i_clock_monitor_enable,
    input  wire logic [WAKE_W-1:0]   i_wakeup_pending_flags,
    input  wire logic [WAKE_W-1:0]   i_wakeup_enable_flags,
    input  wire logic                i_oscillator_output_pin,
    output logic                     o_stop_request_port_bit,
    output logic                     o_idle_request_port_bit,
    output logic                     o_startup_delay_select,
    output logic [IDLE_INTERVAL_SELECT_REG_W-1:0]        o_interval_select_field,
    output logic [7:0]               o_interrupt_control_reg,
    output logic                     o_idle_timer_irq,
    output logic                     o_core_clock_enable,
    output logic                     o_timers_enable,
    output logic                     o_oscillator_enable,
    output logic                     o_supervisor_enable,
    output logic                     o_supervisor_fault_output_n,
    output logic                     o_halted,
    output logic                     o_idling
);
    // =========================================================
    // Pin synchronisers and instruction-cycle divider
    // =========================================================
    logic       reset_pin_low_s;
    logic       osc_pin_s;
    logic       osc_pin_d;
    logic       tick;
    logic       div_run;

    pin_sync #(
        .W      (2)
    ) u_sync (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_ce   (i_ce),
        .i_pin  ({~i_reset_pin_n, i_oscillator_output_pin}),
        .o_sync ({reset_pin_low_s, osc_pin_s})
    );

    cycle_divider u_div (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_ce   (i_ce),
        .i_run  (div_run),
        .o_tick (tick)
    );

    // =========================================================
    // State
    // =========================================================
    ps_state_t             state;
    ps_state_t             next_state;
    logic [IDLE_CNT_W-1:0] idle_cnt;
    logic [IDLE_CNT_W-1:0] next_idle_cnt;
    logic [8:0]            start_cnt;
    logic [8:0]            next_start_cnt;
    logic                  stop_flag;
    logic                  next_stop_flag;
    logic                  idle_flag;
    logic                  next_idle_flag;
    logic                  dly_sel;
    logic                  next_dly_sel;
    logic [IDLE_INTERVAL_SELECT_REG_W-1:0]     interval_select_field;
    logic [IDLE_INTERVAL_SELECT_REG_W-1:0]     next_interval_select_field;
    logic                  pend;
    logic                  next_pend;
    logic                  tap_prev;
    logic                  next_tap_prev;
    logic                  wake_hit;
    logic                  osc_rise;
    logic                  period_hit;
    logic                  need_delay;
    logic [IDLE_CNT_W-1:0] period_mask;
    logic                  reset_hold;

    assign reset_hold = reset_pin_low_s;
    assign wake_hit   = |(i_wakeup_pending_flags & i_wakeup_enable_flags);
    assign osc_rise   = osc_pin_s && !osc_pin_d && i_rc_clock_option;
    assign period_mask = '1 >> (4'(IDLE_CNT_W - 1) - tap_index(interval_select_field));
    assign period_hit = tick
                        && ((idle_cnt & period_mask) == period_mask);
    assign need_delay = !i_rc_clock_option || dly_sel;
    // Oscillator divider stops only while halted, keeping the idle timer.
    assign div_run    = (state != ST_HALT);

    // =========================================================
    // Next-state logic
    // =========================================================
    always_comb begin
        next_state     = state;
        next_start_cnt = start_cnt;
        next_stop_flag = stop_flag;
        next_idle_flag = idle_flag;
        next_dly_sel   = dly_sel;
        next_interval_select_field     = interval_select_field;
        next_idle_cnt  = idle_cnt;
        next_pend      = pend;
        next_tap_prev  = tap_prev;
        if (tick && state != ST_STARTUP) begin
            next_idle_cnt = idle_cnt + 16'h1;
        end
        if (i_startup_delay_select_wr) begin
            next_dly_sel = i_startup_delay_select_val;
        end
        if (i_interval_select_wr) begin
            next_interval_select_field = i_interval_select_field;
        end
        next_tap_prev = idle_cnt[IRQ_TAP_BIT];
        if (i_idle_timer_irq_pending_clr) begin
            next_pend = 1'b0;
        end
        if (idle_cnt[IRQ_TAP_BIT] != tap_prev) begin
            next_pend = 1'b1;
        end
        case (state)
            ST_RUN: begin
                if (i_stop_request_port_bit_wr && i_halt_option_enable
                    && !wake_hit) begin
                    next_stop_flag = 1'b1;
                    next_state     = ST_HALT;
                end else if (i_idle_request_port_bit_wr) begin
                    next_idle_flag = 1'b1;
                    next_state     = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wake_hit || period_hit) begin
                    next_idle_flag = 1'b0;
                    next_state     = ST_RESYNC;
                end
            end
            ST_HALT: begin
                if (wake_hit || osc_rise) begin
                    next_stop_flag = 1'b0;
                    if (need_delay) begin
                        next_start_cnt = STARTUP_COUNT;
                        next_state     = ST_STARTUP;
                    end else begin
                        next_state = ST_RESYNC;
                    end
                end
            end
            ST_STARTUP: begin
                if (tick) begin
                    next_start_cnt = start_cnt - 9'h1;
                    if (start_cnt == 9'h1) begin
                        next_state = ST_RESYNC;
                    end
                end
            end
            ST_RESYNC: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
        if (reset_hold) begin
            next_state     = ST_RUN;
            next_stop_flag = 1'b0;
            next_idle_flag = 1'b0;
            next_dly_sel   = 1'b0;
            next_interval_select_field     = IDLE_INTERVAL_SELECT_REG_RESET;
            next_pend      = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state     <= ST_RUN;
            start_cnt <= '0;
            stop_flag <= 1'b0;
            idle_flag <= 1'b0;
            dly_sel   <= 1'b0;
            interval_select_field     <= IDLE_INTERVAL_SELECT_REG_RESET;
            idle_cnt  <= IDLE_RESET_VAL;
            pend      <= 1'b0;
            tap_prev  <= 1'b0;
            osc_pin_d <= 1'b0;
        end else if (i_ce) begin
            state     <= next_state;
            start_cnt <= next_start_cnt;
            stop_flag <= next_stop_flag;
            idle_flag <= next_idle_flag;
            dly_sel   <= next_dly_sel;
            interval_select_field     <= next_interval_select_field;
            idle_cnt  <= next_idle_cnt;
            pend      <= next_pend;
            tap_prev  <= next_tap_prev;
            osc_pin_d <= osc_pin_s;
        end
    end

    // =========================================================
    // Registered outputs
    // =========================================================
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_stop_request_port_bit     <= 1'b0;
            o_idle_request_port_bit     <= 1'b0;
            o_startup_delay_select      <= 1'b0;
            o_interval_select_field     <= IDLE_INTERVAL_SELECT_REG_RESET;
            o_interrupt_control_reg     <= 8'h00;
            o_idle_timer_irq            <= 1'b0;
            o_core_clock_enable         <= 1'b1;
            o_timers_enable             <= 1'b1;
            o_oscillator_enable         <= 1'b1;
            o_supervisor_enable         <= 1'b1;
            o_supervisor_fault_output_n <= 1'b1;
            o_halted                    <= 1'b0;
            o_idling                    <= 1'b0;
        end else if (i_ce) begin
            o_stop_request_port_bit <= next_stop_flag;
            o_idle_request_port_bit <= next_idle_flag;
            o_startup_delay_select  <= next_dly_sel;
            o_interval_select_field <= next_interval_select_field;
            o_interrupt_control_reg <= 8'h00;
            o_interrupt_control_reg[INTERRUPT_CONTROL_REG_PND_BIT] <= next_pend;
            o_interrupt_control_reg[INTERRUPT_CONTROL_REG_EN_BIT]  <=
                i_idle_timer_irq_enable;
            o_idle_timer_irq <= next_pend && i_idle_timer_irq_enable
                                && i_global_irq_enable;
            o_core_clock_enable <= (next_state == ST_RUN);
            o_timers_enable     <= (next_state == ST_RUN)
                                   || (next_state == ST_RESYNC);
            o_oscillator_enable <= (next_state != ST_HALT);
            o_supervisor_enable <= (next_state != ST_HALT)
                                   && (next_state != ST_STARTUP);
            o_supervisor_fault_output_n <= !(i_clock_monitor_enable
                && (next_state == ST_HALT));
            o_halted <= (next_state == ST_HALT);
            o_idling <= (next_state == ST_IDLE);
        end
    end

    // =========================================================
    // Assertions
    // =========================================================
    property p_halt_refused;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && state == ST_RUN && wake_hit && !reset_hold)
            |=> (state != ST_HALT);
    endproperty
    a_halt_refused: assert property (p_halt_refused)
        else $error("Full-stop entered with wakeup pending.");

    property p_option_off;
        @(posedge i_clk) disable iff (i_rst)
        !i_halt_option_enable |-> ##1 !stop_flag || $past(stop_flag);
    endproperty
    a_option_off: assert property (p_option_off)
        else $error("Stop flag set with option disabled.");

    property p_fault_in_halt;
        @(posedge i_clk) disable iff (i_rst)
        (state == ST_HALT && i_clock_monitor_enable && $past(i_ce))
            |-> !o_supervisor_fault_output_n || !$past(i_clock_monitor_enable);
    endproperty
    a_fault_in_halt: assert property (p_fault_in_halt)
        else $error("Clock fault not shown during full-stop.");

    property p_startup_load;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && state == ST_HALT && next_state == ST_STARTUP)
            |=> (start_cnt == STARTUP_COUNT);
    endproperty
    a_startup_load: assert property (p_startup_load)
        else $error("Start-up count not loaded with 256.");

    property p_no_clock_startup;
        @(posedge i_clk) disable iff (i_rst)
        (state == ST_STARTUP && !reset_hold)
            |=> !o_core_clock_enable || !$past(i_ce);
    endproperty
    a_no_clock_startup: assert property (p_no_clock_startup)
        else $error("Clocks routed during start-up.");

    property p_reset_exit;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && reset_hold) |=> (state == ST_RUN) && (interval_select_field == IDLE_INTERVAL_SELECT_REG_RESET);
    endproperty
    a_reset_exit: assert property (p_reset_exit)
        else $error("Reset pin did not return to run.");

    property p_idle_exit_clears;
        @(posedge i_clk) disable iff (i_rst)
        (i_ce && state == ST_IDLE && wake_hit) |=> !idle_flag;
    endproperty
    a_idle_exit_clears: assert property (p_idle_exit_clears)
        else $error("Idle flag not cleared on wakeup.");

    property p_halt_stops;
        @(posedge i_clk) disable iff (i_rst)
        (o_halted) |-> !o_timers_enable && !o_supervisor_enable;
    endproperty
    a_halt_stops: assert property (p_halt_stops)
        else $error("Activity running during full-stop.");
endmodule
`default_nettype wire

//--- rtl/pin_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module pin_sync
    import power_save_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_ce,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta   <= '0;
            o_sync <= '0;
        end else if (i_ce) begin
            meta   <= i_pin;
            o_sync <= meta;
        end
    end
endmodule
`default_nettype wire

//--- rtl/power_save_pkg.sv
// Constants and types shared by the power-save controller.
package power_save_pkg;
    // =========================================================
    // Widths and timing
    // =========================================================
    localparam int          WAKE_W          = 8;
    localparam int          IDLE_INTERVAL_SELECT_REG_W          = 3;
    localparam int          IDLE_CNT_W      = 16;
    localparam int          DIV_W           = 4;
    localparam logic [3:0]  CYCLE_DIVIDE    = 4'hA;
    localparam logic [3:0]  DIV_LAST        = 4'h9;
    localparam logic [8:0]  STARTUP_COUNT   = 9'h100;
    localparam logic [15:0] IDLE_RESET_VAL  = 16'h0000;
    localparam logic [2:0]  IDLE_INTERVAL_SELECT_REG_RESET      = 3'h0;
    localparam int          IRQ_TAP_BIT     = 12;
    localparam int          IDLE_INTERVAL_SELECT_REG_TOP_BIT    = 2;
    localparam int          INTERRUPT_CONTROL_REG_PND_BIT  = 5;
    localparam int          INTERRUPT_CONTROL_REG_EN_BIT   = 4;
    localparam int          TAP_BASE        = 11;
    localparam logic [1:0]  TAP_TOP_SEL     = 2'h3;

    // =========================================================
    // Sequencer states
    // =========================================================
    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_HALT    = 3'b001,
        ST_STARTUP = 3'b011,
        ST_RESYNC  = 3'b010,
        ST_IDLE    = 3'b100
    } ps_state_t;

    // Returns the bit index of the idle period tap for a select code.
    function automatic logic [3:0] tap_index(input logic [2:0] sel);
        logic [1:0] low;
        low = sel[IDLE_INTERVAL_SELECT_REG_TOP_BIT] ? TAP_TOP_SEL + 2'h0 : sel[1:0];
        if (sel[IDLE_INTERVAL_SELECT_REG_TOP_BIT]) begin
            tap_index = 4'(TAP_BASE) + 4'h4 + 4'h0;
        end else begin
            tap_index = 4'(TAP_BASE) + {2'h0, low};
        end
    endfunction
endpackage

//--- verif/core_model.sv
// Behavioural CPU core model that writes the power-save flags.
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input  wire logic i_clk,
    output logic      o_stop_wr,
    output logic      o_idle_wr
);
    initial begin
        o_stop_wr = 1'b0;
        o_idle_wr = 1'b0;
    end

    // =========================================================
    // Flag write
    // =========================================================
    // Writes one flag as a one-cycle pulse, then spends two idle cycles.
    task automatic write_flag(input logic stop);
        @(posedge i_clk);
        o_stop_wr <= stop;
        o_idle_wr <= !stop;
        @(posedge i_clk);
        o_stop_wr <= 1'b0;
        o_idle_wr <= 1'b0;
        repeat (2) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- verif/halt_idle_power_save_control_test.sv
// Self-checking testbench for the power-save sequencer.
`timescale 1ns/100ps
`default_nettype none
module halt_idle_power_save_control_test;
    import power_save_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic rst_pin_n = 1'b1, halt_opt = 1'b1, rc = 1'b0, dly_wr = 1'b0;
    logic dly_val = 1'b0, sel_wr = 1'b0, irq_en = 1'b0, pnd_clr = 1'b0;
    logic global_irq_enable = 1'b0, mon_en = 1'b1, pin = 1'b0, ce = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [7:0] wk_pnd = 8'h00, wk_en = 8'h00;
    logic stop_wr, idle_wr, stop_f, idle_f, dly_f, irq, core_en;
    logic tmr_en, osc_en, sup_en, fault_n, halted, idling;
    logic [2:0] sel_f;
    logic [7:0] interrupt_control_reg;
    int errors = 0;
    int num_checks = 0;

    always #2.5 i_clk = ~i_clk;

    core_model cpu (.i_clk(i_clk), .o_stop_wr(stop_wr), .o_idle_wr(idle_wr));

    halt_idle_power_save_control uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
        .i_reset_pin_n(rst_pin_n), .i_halt_option_enable(halt_opt),
        .i_rc_clock_option(rc), .i_stop_request_port_bit_wr(stop_wr),
        .i_idle_request_port_bit_wr(idle_wr),
        .i_startup_delay_select_wr(dly_wr),
        .i_startup_delay_select_val(dly_val),
        .i_interval_select_wr(sel_wr), .i_interval_select_field(sel),
        .i_idle_timer_irq_enable(irq_en),
        .i_idle_timer_irq_pending_clr(pnd_clr),
        .i_global_irq_enable(global_irq_enable), .i_clock_monitor_enable(mon_en),
        .i_wakeup_pending_flags(wk_pnd), .i_wakeup_enable_flags(wk_en),
        .i_oscillator_output_pin(pin),
        .o_stop_request_port_bit(stop_f), .o_idle_request_port_bit(idle_f),
        .o_startup_delay_select(dly_f), .o_interval_select_field(sel_f),
        .o_interrupt_control_reg(interrupt_control_reg), .o_idle_timer_irq(irq),
        .o_core_clock_enable(core_en), .o_timers_enable(tmr_en),
        .o_oscillator_enable(osc_en), .o_supervisor_enable(sup_en),
        .o_supervisor_fault_output_n(fault_n), .o_halted(halted),
        .o_idling(idling)
    );

    // =========================================================
    // Shared tasks
    // =========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // Waits, bounded, for run (0), end of idle (1) or timer pending (2).
    task automatic wait_lvl(input int which, input int limit);
        int n;
        n = 0;
        while (n < limit && !((which == 0 && core_en === 1'b1) ||
               (which == 1 && idling === 1'b0) ||
               (which == 2 && interrupt_control_reg[INTERRUPT_CONTROL_REG_PND_BIT] === 1'b1))) begin
            step(1);
            n++;
        end
    endtask

    task automatic wake(input logic on);
        @(posedge i_clk);
        wk_pnd <= on ? 8'h01 : 8'h00;
        wk_en  <= on ? 8'h01 : 8'h00;
    endtask

    task automatic finish_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_reset;
        check(dly_f, 1'b0);
        check(sel_f, IDLE_INTERVAL_SELECT_REG_RESET);
        check(core_en, 1'b1);
        check(fault_n, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_refuse;
        @(posedge i_clk) halt_opt <= 1'b0;
        cpu.write_flag(1'b1);
        #1;
        check(stop_f, 1'b0);
        check(halted, 1'b0);
        @(posedge i_clk) halt_opt <= 1'b1;
        wake(1'b1);
        cpu.write_flag(1'b1);
        #1;
        check(halted, 1'b0);
        wake(1'b0);
        $display("test refuse done");
    endtask

    task automatic t_halt_startup;
        cpu.write_flag(1'b1);
        #1;
        check({halted, stop_f}, 2'h3);
        check({core_en, tmr_en, osc_en, sup_en}, 4'h0);
        check(fault_n, 1'b0);
        wake(1'b1);
        step(2);
        check({osc_en, core_en}, 2'h2);
        wake(1'b0);
        step(2530);
        check(core_en, 1'b0);
        wait_lvl(0, 60);
        check(core_en, 1'b1);
        check({stop_f, fault_n}, 2'h1);
        $display("test halt startup done");
    endtask

    task automatic t_rc_and_pin;
        @(posedge i_clk) rc <= 1'b1;
        mon_en <= 1'b0;
        cpu.write_flag(1'b1);
        #1;
        check(halted, 1'b1);
        check(fault_n, 1'b1);
        @(posedge i_clk) pin <= 1'b1;
        wait_lvl(0, 12);
        check({core_en, halted}, 2'h2);
        @(posedge i_clk) pin <= 1'b0;
        {dly_val, dly_wr} <= 2'h3;
        @(posedge i_clk) dly_wr <= 1'b0;
        step(1);
        check(dly_f, 1'b1);
        cpu.write_flag(1'b1);
        @(posedge i_clk) rst_pin_n <= 1'b0;
        step(5);
        check({halted, stop_f}, 2'h0);
        check(dly_f, 1'b0);
        @(posedge i_clk) rst_pin_n <= 1'b1;
        rc <= 1'b0;
        mon_en <= 1'b1;
        step(3);
        $display("test rc and pin done");
    endtask

    task automatic t_idle;
        @(posedge i_clk) {sel, sel_wr} <= {3'h6, 1'b1};
        @(posedge i_clk) {sel, sel_wr} <= {3'h0, 1'b0};
        step(1);
        check(sel_f, 3'h6);
        @(posedge i_clk) sel_wr <= 1'b1;
        {irq_en, global_irq_enable} <= 2'h3;
        @(posedge i_clk) sel_wr <= 1'b0;
        cpu.write_flag(1'b0);
        #1;
        check({idling, idle_f, core_en, tmr_en}, 4'hC);
        check({osc_en, sup_en}, 2'h3);
        wait_lvl(1, 42000);
        check({idling, idle_f, sel_f}, 5'h00);
        wait_lvl(2, 42000);
        step(2);
        check(interrupt_control_reg, 8'h30);
        check(irq, 1'b1);
        @(posedge i_clk) global_irq_enable <= 1'b0;
        step(3);
        check(irq, 1'b0);
        @(posedge i_clk) pnd_clr <= 1'b1;
        @(posedge i_clk) pnd_clr <= 1'b0;
        step(2);
        check(interrupt_control_reg, 8'h10);
        cpu.write_flag(1'b0);
        @(posedge i_clk) ce <= 1'b0;
        wake(1'b1);
        step(4);
        check(idling, 1'b1);
        @(posedge i_clk) ce <= 1'b1;
        wait_lvl(1, 8);
        check(idling, 1'b0);
        wake(1'b0);
        $display("test idle done");
    endtask

    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        step(3);
        t_reset();
        t_refuse();
        t_halt_startup();
        t_rc_and_pin();
        t_idle();
        finish_test();
    end

    initial begin
        #500000;
        errors++;
        finish_test();
    end
endmodule
`default_nettype wire
